// >>> design/cal_device.sv
`timescale 1ns/1ps
// Function
// R1 - Latency counts select-low to command registration
// R2 - Only mode-set commands switch latency on/off
// R3 - Controller programs latency as rounded clock count
// R4 - Select low enables command/address receivers
// R5 - Receivers may turn off once select high
// R6 - Receivers stay on through back-to-back selects
// R7 - Command waits mode-set delay plus latency
// R8 - Mode-sets spaced by mode-set delay plus latency
// R9 - Extended delays use newly programmed latency
// R10 - Termination control timing ignores the latency
// R11 - Latency off registers command with select
module cal_device
    import cal_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    cal_link_if.device link,
    output logic cmd_valid,
    output logic [CMD_W-1:0] cmd_out,
    output logic [ADDR_W-1:0] addr_out,
    output logic odt_out,
    output logic receivers_on,
    output logic [CAL_W-1:0] cal_value
);
    // Every clock the select pin is shifted into a short line with one entry
    // per clock of the longest latency. The entry at the depth of the
    // programmed latency names the cycle whose command and address are
    // registered, and it is the only one looked at in that cycle.
    // Entries leave the line once their command is due, so a change of
    // latency never replays an old select, and back-to-back selects simply
    // stand at neighbouring depths.
    // A mode-set is taken only together with a due select, and the latency
    // that it carries counts from the next clock on.
    // The receiver enable is a registered status level. It rises a clock after
    // the select, which is in time for any latency above zero; with the mode
    // off it carries no timing meaning.

    // One entry per clock of the longest latency the mode field can hold.
    localparam int LINE_N = 1 << CAL_W;

    // Bit k of the line is a select that was seen low k clocks ago; bit 0 is
    // the select on the pins in this very cycle.
    logic [LINE_N-1:0] sel_line;
    logic [LINE_N-2:0] sel_hist;
    logic [LINE_N-2:0] next_sel_hist;
    logic sel_now;

    // Depth masks: due at the latency, waiting up to it, kept below it.
    logic [LINE_N-1:0] due_mask;
    logic [LINE_N-1:0] wait_mask;
    logic [LINE_N-2:0] keep_mask;
    logic [LINE_N-1:0] sel_waiting;

    // Latency mode state and the select whose command is due now.
    logic latency_on;
    logic sel_due;
    logic pending;

    // Mode-set decode and the latency that it carries.
    logic cmd_is_mode_set;
    logic mode_set;
    logic [CAL_W-1:0] new_cal;

    // Next values of the registered outputs.
    logic next_cmd_valid;
    logic [CMD_W-1:0] next_cmd_out;
    logic [ADDR_W-1:0] next_addr_out;
    logic next_odt_out;
    logic next_receivers_on;
    logic [CAL_W-1:0] next_cal_value;

    // The select pin is active low; everything inside works on a high level.
    assign sel_now = ~link.cs_n;
    assign sel_line = {sel_hist, sel_now};

    // A zero in the latency field is the mode switched off.
    assign latency_on = (cal_value != '0);

    genvar k;
    generate
        for (k = 0; k < LINE_N; k = k + 1) begin : g_bit
            // Each depth compares itself with the latency in force, so a new
            // latency takes effect on every entry at the same clock.
            assign due_mask[k] = (CAL_W'(k) == cal_value);
            assign wait_mask[k] = (CAL_W'(k) <= cal_value);
            assign sel_waiting[k] = sel_line[k] && wait_mask[k];
            if (k < LINE_N - 1) begin : g_keep
                // A select leaves the line once its command is due. Were it kept,
                // a mode-set that raises the latency would meet its own select
                // again a few clocks later and register a phantom command.
                assign keep_mask[k] = (CAL_W'(k) < cal_value);
                assign next_sel_hist[k] = sel_line[k] && keep_mask[k];
            end
        end
    endgenerate

    // With the mode off the command travels with its own select. With the
    // mode on it arrives the programmed number of clocks after its select.
    assign sel_due = latency_on ? |(sel_line & due_mask) : sel_now; // R1 R11

    // The receivers stay on while any select still waits for its command.
    // Back-to-back selects overlap in the line, so the receivers never drop
    // between them; they go off the clock after the last command is taken.
    assign pending = |sel_waiting; // R4 R6
    assign next_receivers_on = pending; // R5

    // Only a due select qualifies a mode-set; a mode-set code on the bus in
    // any other cycle is not a command and must not move the latency.
    assign cmd_is_mode_set = (link.cmd == CMD_MODE_SET);
    assign mode_set = sel_due && cmd_is_mode_set; // R2
    assign new_cal = link.addr[CAL_FIELD_LSB +: CAL_W];

    // The new latency governs from the clock after the mode-set is taken, so
    // the mode-set itself is always timed by the latency that was in force.
    assign next_cal_value = mode_set ? new_cal : cal_value; // R2 R9

    // The registered command holds its value until the next one is taken.
    assign next_cmd_valid = sel_due; // R1
    assign next_cmd_out = sel_due ? link.cmd : cmd_out;
    assign next_addr_out = sel_due ? link.addr : addr_out;

    // Termination control goes through one stage whatever the latency, so its
    // relation to the bus is the same with the mode on or off.
    assign next_odt_out = link.on_die_termination_control; // R10

    // Selects in flight. Reset empties the line, so no select seen before reset
    // can fall due after it, though with the mode off a select on the pins in the
    // first clock is taken at once; a select that is low while reset is held is never answered.
    // The line and cal_value are the only state that the latency itself depends on.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            sel_hist <= '0;
        end else begin
            sel_hist <= next_sel_hist;
        end
    end

    // Receiver enable. It is reported only and gates nothing here, so it
    // costs no input timing. A real buffer gated by it would have to be
    // opened a clock sooner when the mode is off.
    // It reads low after reset, matching the empty line.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            receivers_on <= 1'b0;
        end else begin
            receivers_on <= next_receivers_on;
        end
    end

    // One-clock strobe for each command taken. Consecutive due selects give
    // consecutive strobes, one per command, with no gap forced between them.
    // A reader that needs a gap must get it from the controller.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cmd_valid <= 1'b0;
        end else begin
            cmd_valid <= next_cmd_valid;
        end
    end

    // The command holds until the next one is taken, so a slow reader can
    // still pick it up after the strobe has gone.
    // Reset shows the no-operation code rather than a live command.
    // Nothing here checks that the code is one the device knows.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cmd_out <= CMD_NOP;
        end else begin
            cmd_out <= next_cmd_out;
        end
    end

    // The address is captured in the same cycle as the command, so the two
    // always belong to the same select even with selects back to back.
    // Reset clears it to zero.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            addr_out <= '0;
        end else begin
            addr_out <= next_addr_out;
        end
    end

    // Termination level, one clock behind the pin in both modes. It is not
    // held back by the latency on purpose: delaying it would shift it
    // against the command bus as soon as the mode is switched on.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            odt_out <= 1'b0;
        end else begin
            odt_out <= next_odt_out;
        end
    end

    // Latency in force. Reset leaves the mode off, so the first mode-set
    // is always taken together with its own select.
    // Only a mode-set changes it; ordinary commands that happen to carry
    // ones in the latency field leave it alone.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cal_value <= CAL_RESET;
        end else begin
            cal_value <= next_cal_value;
        end
    end
endmodule

// >>> design/cal_host.sv
`timescale 1ns/1ps
// Drives one command at a time; delays the fields by the programmed latency.
module cal_host
    import cal_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic req_valid,
    input wire logic [CMD_W-1:0] req_cmd,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic req_odt,
    output logic req_ready,
    cal_link_if.host link
);
    cal_host_state_t state;
    logic [CAL_W-1:0] cal_cur;
    logic [CAL_W-1:0] cnt;
    logic [7:0] gap;
    logic [CMD_W-1:0] hold_cmd;
    logic [ADDR_W-1:0] hold_addr;
    wire take = (state == CAL_HOST_IDLE) && req_valid && (gap == 8'h00);
    wire is_ms = (hold_cmd == CMD_MODE_SET);
    wire [CAL_W-1:0] next_cal = is_ms ? hold_addr[CAL_FIELD_LSB +: CAL_W] : cal_cur; // R9
    wire [7:0] ms_gap = 8'(MODE_SET_TO_COMMAND_DELAY) + 8'(next_cal); // R7 R8
    wire fire = (state == CAL_HOST_SELECT && cal_cur == '0) ||
        (state == CAL_HOST_WAIT && cnt == '0);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state <= CAL_HOST_IDLE;
            cal_cur <= CAL_RESET;
            cnt <= '0;
            gap <= 8'h00;
            hold_cmd <= CMD_NOP;
            hold_addr <= '0;
            req_ready <= 1'b0;
            link.cs_n <= 1'b1;
            link.cmd <= CMD_NOP;
            link.addr <= '0;
            link.on_die_termination_control <= 1'b0;
        end else begin
            link.on_die_termination_control <= req_odt; // R10
            req_ready <= 1'b0;
            if (gap != 8'h00) begin
                gap <= gap - 8'h01;
            end
            case (state)
                CAL_HOST_IDLE: begin
                    link.cs_n <= 1'b1;
                    link.cmd <= CMD_NOP;
                    if (take) begin
                        hold_cmd <= req_cmd;
                        hold_addr <= req_addr;
                        link.cs_n <= 1'b0;
                        if (cal_cur == '0) begin
                            link.cmd <= req_cmd;
                            link.addr <= req_addr;
                        end
                        cnt <= cal_cur - 3'h1;
                        state <= CAL_HOST_SELECT;
                    end
                end
                CAL_HOST_SELECT: begin
                    link.cs_n <= 1'b1;
                    link.cmd <= CMD_NOP;
                    state <= CAL_HOST_WAIT;
                    if (cal_cur == '0) begin
                        state <= CAL_HOST_IDLE;
                    end else if (cal_cur == 3'h1) begin
                        link.cmd <= hold_cmd; // R1
                        link.addr <= hold_addr;
                    end
                end
                default: begin
                    link.cmd <= CMD_NOP;
                    if (cnt != '0) begin
                        cnt <= cnt - 3'h1;
                        if (cnt == 3'h1) begin
                            link.cmd <= hold_cmd;
                            link.addr <= hold_addr;
                        end
                    end else begin
                        state <= CAL_HOST_IDLE;
                    end
                end
            endcase
            if (fire) begin
                req_ready <= 1'b1;
                if (is_ms) begin
                    cal_cur <= next_cal; // R3
                    gap <= ms_gap;
                end
            end
        end
    end
endmodule

// >>> design/cal_link_if.sv
`timescale 1ns/1ps
interface cal_link_if;
    import cal_pkg::*;
    logic cs_n;
    logic [CMD_W-1:0] cmd;
    logic [ADDR_W-1:0] addr;
    logic on_die_termination_control;
    modport host (output cs_n, output cmd, output addr, output on_die_termination_control);
    modport device (input cs_n, input cmd, input addr, input on_die_termination_control);
endinterface

// >>> design/cal_pkg.sv
package cal_pkg;
    // Command/address field widths of this model.
    localparam int CMD_W = 4;
    localparam int ADDR_W = 18;
    localparam int CAL_W = 3;
    // Mode-set command code and the bits of its address that carry the latency.
    localparam logic [3:0] CMD_MODE_SET = 4'h0;
    localparam logic [3:0] CMD_NOP = 4'hf;
    localparam int CAL_FIELD_LSB = 6;
    // Delay from a mode-set command to the next command, in clocks, latency off.
    localparam int MODE_SET_TO_COMMAND_DELAY = 24;
    localparam logic [CAL_W-1:0] CAL_RESET = 3'h0;
    typedef enum logic [1:0] {
        CAL_HOST_IDLE,
        CAL_HOST_SELECT,
        CAL_HOST_WAIT
    } cal_host_state_t;
endpackage

// >>> tb/cal_props.sv
`timescale 1ns/1ps
module cal_props
    import cal_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic [CMD_W-1:0] cmd,
    input wire logic [ADDR_W-1:0] addr
);
    logic [CAL_W-1:0] cal;
    wire live = cmd != CMD_NOP;
    wire mset = cmd == CMD_MODE_SET;
    // A mode-set travels with the old latency, so the copy updates after it.
    always_ff @(posedge core_clk) cal <= rst ? CAL_RESET : mset ? addr[CAL_FIELD_LSB +: CAL_W] : cal;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence s_sel3; !cs_n && cal == 3'h3; endsequence
    property p_now; !cs_n && cal == 3'h0 |-> live; endproperty
    a_now: assert property (p_now) else $error("late cmd");
    property p_lat3; s_sel3 |-> !live ##1 !live ##1 !live ##1 live; endproperty
    a_lat3: assert property (p_lat3) else $error("cal 3 slip");
    property p_lat7; !cs_n && cal == 3'h7 |-> ##7 live; endproperty
    a_lat7: assert property (p_lat7) else $error("cal 7 slip");
    property p_src; live && cal == 3'h3 |-> $past(cs_n, 3) == 1'b0; endproperty
    a_src: assert property (p_src) else $error("no select");
    property p_sel; !cs_n |=> cs_n; endproperty
    a_sel: assert property (p_sel) else $error("long select");
    property p_one; live |=> !live; endproperty
    a_one: assert property (p_one) else $error("long cmd");
    property p_rst; $past(rst) |-> cs_n && !live; endproperty
    a_rst: assert property (p_rst) else $error("busy after reset");
    property p_gap; mset |-> not (##[1:23] live); endproperty
    a_gap: assert property (p_gap) else $error("mode gap short");
endmodule

// >>> tb/test_command_address_latency_gate.sv
`timescale 1ns/1ps
module test_command_address_latency_gate;
    import cal_pkg::*;
    logic core_clk = 1'b0, rst = 1'b1, req_valid = 1'b0, req_ready, cmd_valid, receivers_on;
    logic [CMD_W-1:0] req_cmd = CMD_NOP, cmd_out;
    logic [ADDR_W-1:0] req_addr = '0, addr_out;
    logic [CAL_W-1:0] cal_value;
    logic req_odt = 1'b0, odt_out;
    int fail_count = 0, cmp_count = 0, n;
    cal_link_if link();
    cal_host cal_host_i(.core_clk, .rst, .req_valid, .req_cmd, .req_addr, .req_odt,
        .req_ready, .link);
    cal_device cal_device_i(.core_clk, .rst, .link, .cmd_valid, .cmd_out, .addr_out,
        .odt_out, .receivers_on, .cal_value);
    cal_props cal_props_i(.core_clk, .rst, .cs_n(link.cs_n), .cmd(link.cmd), .addr(link.addr));
    always #50 core_clk = ~core_clk;
    task automatic chk(input logic [31:0] seen, exp);
        cmp_count++;
        if (seen !== exp) fail_count++;
        if (seen !== exp) $display("mismatch at %0t: %h not %h", $time, seen, exp);
    endtask
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Waits out the longest mode-set gap first, since the host drops early requests.
    task automatic send(input logic [3:0] c, input logic [17:0] a, input int lat);
        repeat (40) @(posedge core_clk);
        req_valid <= 1'b1;
        req_odt <= 1'b1;
        req_cmd <= c;
        req_addr <= a;
        @(posedge core_clk);
        req_valid <= 1'b0;
        req_odt <= 1'b0;
        for (n = 0; n < 60 && cmd_valid !== 1'b1; n++) begin
            @(negedge core_clk);
            if (n == 1) chk(odt_out, 1'b1);
            if (n == 2 && lat > 0) chk(receivers_on, 1'b1);
        end
        chk(n, lat + 2);
        if (n == 60) stop_test();
        chk(cmd_out, c);
        chk(req_ready, 1'b1);
        repeat (3) @(negedge core_clk);
        chk(receivers_on, 1'b0);
    endtask
    task automatic switch_latency(input logic [2:0] old_lat, input logic [2:0] lat);
        send(CMD_MODE_SET, {9'h0, lat, 6'h0}, old_lat);
        chk(cal_value, lat);
        send(4'h1, 18'h001c0, lat);
        chk(cal_value, lat);
    endtask
    initial begin
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        switch_latency(3'h0, 3'h3);
        switch_latency(3'h3, 3'h7);
        switch_latency(3'h7, 3'h0);
        stop_test();
    end
endmodule
